// File: design/ortt_pkg.sv
// Shared constants, types and the register map of the optical ring test pattern transmitter.
`default_nettype none

package ortt_pkg;

    // Local clock period and nominal bit cell periods, in picoseconds.
    localparam int unsigned PS_W                 = 20;
    localparam logic [19:0] CLK_PERIOD_PS        = 20'h09c40;
    localparam logic [19:0] NOM_BIT_PERIOD_PS_2  = 20'h7a120;
    localparam logic [19:0] NOM_BIT_PERIOD_PS_4  = 20'h3d090;
    localparam logic [19:0] NOM_BIT_PERIOD_PS_8  = 20'h1e848;
    localparam logic [19:0] NOM_BIT_PERIOD_PS_16 = 20'h0f424;

    typedef enum logic [1:0] {
        RATE_2M,
        RATE_4M,
        RATE_8M,
        RATE_16M
    } ortt_rate_t;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_STEADY,
        MODE_ZERO
    } ortt_mode_t;

    // APB register map.
    localparam int unsigned ADDR_W        = 12;
    localparam logic [11:0] CTRL_OFFSET   = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;

    // Control register fields.
    localparam int unsigned CTRL_W        = 8;
    localparam int unsigned CTRL_SEL_LSB  = 0;
    localparam int unsigned CTRL_INVERT   = 2;
    localparam int unsigned CTRL_MASTER   = 3;
    localparam int unsigned CTRL_RATE_LSB = 4;
    localparam int unsigned CTRL_EXT      = 6;
    localparam int unsigned CTRL_AUTO     = 7;
    localparam logic [7:0]  CTRL_RST      = 8'h08;

    // Status register fields.
    localparam int unsigned STAT_MODE_LSB = 0;
    localparam int unsigned STAT_TEST     = 2;
    localparam int unsigned STAT_RATE_LSB = 3;
    localparam int unsigned STAT_LIGHT    = 5;
    localparam int unsigned STAT_LINE     = 6;

    function automatic logic [19:0] ortt_period_ps(input ortt_rate_t r);
        logic [19:0] p;
        p = NOM_BIT_PERIOD_PS_2;
        unique case (r)
            RATE_2M:  p = NOM_BIT_PERIOD_PS_2;
            RATE_4M:  p = NOM_BIT_PERIOD_PS_4;
            RATE_8M:  p = NOM_BIT_PERIOD_PS_8;
            RATE_16M: p = NOM_BIT_PERIOD_PS_16;
        endcase
        return p;
    endfunction

endpackage : ortt_pkg

`default_nettype wire

// File: design/ortt_bit_timer.sv
// Fractional bit cell timer that emits one tick per bit cell of the local clock.
`default_nettype none

module ortt_bit_timer (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Bit cell period in picoseconds
    input  wire logic [19:0] period_ps,
    // One pulse per bit cell
    output logic             tick
);

    typedef struct packed {
        logic [19:0] acc;
    } ortt_timer_state_t;

    ortt_timer_state_t s_reg;
    ortt_timer_state_t s_next;
    logic [19:0]       sum;

    // The residue carries over, so 12,5 cycles per cell comes out exact on average.
    always_comb begin
        s_next = s_reg;
        sum    = s_reg.acc + ortt_pkg::CLK_PERIOD_PS;
        tick   = 1'b0;
        if (sum >= period_ps) begin
            tick       = 1'b1;
            s_next.acc = sum - period_ps;
        end else begin
            s_next.acc = sum;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

endmodule // ortt_bit_timer

`default_nettype wire

// File: design/ortt_tx.sv
// Transmit-side test pattern, repeater and rate logic with its APB register slave.
`default_nettype none

module ortt_tx (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // APB slave
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Optical receiver and transmitter
    input  wire logic        light_in,
    output logic             opt_tx,
    // Dedicated test key
    input  wire logic        test_key,
    // Data-link side
    input  wire logic        tx_bit,
    output logic             bit_strobe,
    // Automatic baud rate detector
    input  wire logic [1:0]  auto_rate
);

    typedef struct packed {
        logic [7:0]         ctrl;
        logic [31:0]        prdata;
        logic               light_s1;
        logic               light_s2;
        logic               key_s1;
        logic               key_s2;
        logic               key_prev;
        logic               test_active;
        ortt_pkg::ortt_mode_t mode;
        ortt_pkg::ortt_rate_t rate;
        logic               line;
    } ortt_tx_state_t;

    ortt_tx_state_t       s_reg;
    ortt_tx_state_t       s_next;
    logic                 tick;
    logic [19:0]          period_ps;
    logic                 key_rise;
    logic                 is_master;
    logic                 invert;
    logic                 ext_class;
    logic [1:0]           sel;
    ortt_pkg::ortt_mode_t req_mode;
    ortt_pkg::ortt_rate_t req_rate;
    logic                 apb_setup;
    logic                 apb_access;
    logic                 hit_ctrl;
    logic                 hit_status;
    logic [31:0]          status_word;

    assign period_ps = ortt_pkg::ortt_period_ps(s_reg.rate);

    ortt_bit_timer u_timer (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .period_ps (period_ps),
        .tick      (tick)
    );

    assign is_master  = s_reg.ctrl[ortt_pkg::CTRL_MASTER];
    assign invert     = s_reg.ctrl[ortt_pkg::CTRL_INVERT];
    assign ext_class  = s_reg.ctrl[ortt_pkg::CTRL_EXT];
    assign sel        = s_reg.ctrl[ortt_pkg::CTRL_SEL_LSB +: 2];
    assign key_rise   = s_reg.key_s2 & ~s_reg.key_prev;
    assign apb_setup  = psel & ~penable;
    assign apb_access = psel & penable;
    assign hit_ctrl   = (paddr == ortt_pkg::CTRL_OFFSET);
    assign hit_status = (paddr == ortt_pkg::STATUS_OFFSET);

    // The slave never stretches a transfer; unmapped addresses answer with an error.
    assign pready     = 1'b1;
    assign pslverr    = apb_access & ~(hit_ctrl | hit_status);
    assign prdata     = s_reg.prdata;
    assign opt_tx     = s_reg.line;
    assign bit_strobe = tick & is_master & (s_reg.mode == ortt_pkg::MODE_NORMAL);

    always_comb begin
        status_word = '0;
        status_word[ortt_pkg::STAT_MODE_LSB +: 2] = s_reg.mode;
        status_word[ortt_pkg::STAT_TEST]          = s_reg.test_active;
        status_word[ortt_pkg::STAT_RATE_LSB +: 2] = s_reg.rate;
        status_word[ortt_pkg::STAT_LIGHT]         = s_reg.light_s2;
        status_word[ortt_pkg::STAT_LINE]          = s_reg.line;
    end

    // Test patterns only apply while the key has armed test mode.
    always_comb begin
        req_mode = ortt_pkg::MODE_NORMAL;
        if (s_reg.test_active) begin
            if (sel == 2'(ortt_pkg::MODE_STEADY)) begin
                req_mode = ortt_pkg::MODE_STEADY;
            end else if (sel == 2'(ortt_pkg::MODE_ZERO)) begin
                req_mode = ortt_pkg::MODE_ZERO;
            end
        end
    end

    // A basic-class station falls back to 2 Mbit/s if a rate it may not offer is asked for.
    always_comb begin
        req_rate = ortt_pkg::ortt_rate_t'(s_reg.ctrl[ortt_pkg::CTRL_RATE_LSB +: 2]);
        if (ext_class && s_reg.ctrl[ortt_pkg::CTRL_AUTO]) begin
            req_rate = ortt_pkg::ortt_rate_t'(auto_rate);
        end
        if (!ext_class && (req_rate == ortt_pkg::RATE_8M || req_rate == ortt_pkg::RATE_16M)) begin
            req_rate = ortt_pkg::RATE_2M;
        end
    end

    always_comb begin
        s_next          = s_reg;
        s_next.light_s1 = light_in;
        s_next.light_s2 = s_reg.light_s1;
        s_next.key_s1   = test_key;
        s_next.key_s2   = s_reg.key_s1;
        s_next.key_prev = s_reg.key_s2;
        if (key_rise) begin
            s_next.test_active = ~s_reg.test_active;
        end
        if (tick) begin
            s_next.mode = req_mode;
            s_next.rate = req_rate;
        end
        unique case (s_reg.mode)
            ortt_pkg::MODE_STEADY: begin
                s_next.line = 1'b1;
            end
            ortt_pkg::MODE_ZERO: begin
                // Edges come from the local timer only, never from the received stream.
                if (tick) begin
                    s_next.line = ~s_reg.line;
                end
            end
            ortt_pkg::MODE_NORMAL: begin
                if (is_master) begin
                    if (tick && !tx_bit) begin
                        s_next.line = ~s_reg.line;
                    end
                end else begin
                    s_next.line = s_reg.light_s2 ^ invert;
                end
            end
            // The spare mode code is never requested; a dark line is the safe answer.
            default: begin
                s_next.line = 1'b0;
            end
        endcase
        if (apb_setup && !pwrite) begin
            s_next.prdata = '0;
            if (hit_ctrl) begin
                s_next.prdata[ortt_pkg::CTRL_W-1:0] = s_reg.ctrl;
            end else if (hit_status) begin
                s_next.prdata = status_word;
            end
        end
        if (apb_access && pwrite && hit_ctrl) begin
            for (int i = 0; i < ortt_pkg::CTRL_W; i++) begin
                if (pstrb[i / 8]) begin
                    s_next.ctrl[i] = pwdata[i];
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_reg             <= '0;
            s_reg.ctrl        <= ortt_pkg::CTRL_RST;
            s_reg.mode        <= ortt_pkg::MODE_NORMAL;
            s_reg.rate        <= ortt_pkg::RATE_2M;
        end else begin
            s_reg <= s_next;
        end
    end

    // Helper for the bit period checks: cycles since the last tick, valid while rate is steady.
    logic [4:0] gap_cnt;
    logic       gap_valid;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            gap_cnt   <= '0;
            gap_valid <= 1'b0;
        end else if (tick) begin
            gap_cnt   <= '0;
            gap_valid <= (s_next.rate == s_reg.rate);
        end else begin
            gap_cnt   <= gap_cnt + 5'h01;
        end
    end

    sequence s_zero_tick;
        s_reg.mode == ortt_pkg::MODE_ZERO && tick;
    endsequence

    sequence s_toggled;
        ##1 opt_tx != $past(opt_tx);
    endsequence

    property p_steady_high;
        @(posedge ref_clk) disable iff (rst)
        s_reg.mode == ortt_pkg::MODE_STEADY |=> opt_tx;
    endproperty
    a_steady_high: assert property (p_steady_high) else $error("steady light not high");

    property p_repeat;
        @(posedge ref_clk) disable iff (rst)
        (s_reg.mode == ortt_pkg::MODE_NORMAL && !is_master && !invert)
            |=> opt_tx == $past(s_reg.light_s2);
    endproperty
    a_repeat: assert property (p_repeat) else $error("repeater output wrong");

    property p_invert;
        @(posedge ref_clk) disable iff (rst)
        (s_reg.mode == ortt_pkg::MODE_NORMAL && !is_master && invert)
            |=> opt_tx != $past(s_reg.light_s2);
    endproperty
    a_invert: assert property (p_invert) else $error("inverted repeat wrong");

    property p_zero_toggle;
        @(posedge ref_clk) disable iff (rst)
        s_zero_tick |-> s_toggled;
    endproperty
    a_zero_toggle: assert property (p_zero_toggle) else $error("zero stream missed toggle");

    property p_zero_local;
        @(posedge ref_clk) disable iff (rst)
        (s_reg.mode == ortt_pkg::MODE_ZERO && !tick) |=> $stable(opt_tx);
    endproperty
    a_zero_local: assert property (p_zero_local) else $error("zero stream edge off tick");

    property p_bit_period;
        @(posedge ref_clk) disable iff (rst)
        (tick && gap_valid) |->
            (32'(gap_cnt) + 1 >= 32'(period_ps) / 32'(ortt_pkg::CLK_PERIOD_PS)) &&
            (32'(gap_cnt) + 1 <= (32'(period_ps) + 32'(ortt_pkg::CLK_PERIOD_PS) - 1) /
                                 32'(ortt_pkg::CLK_PERIOD_PS));
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit cell length out of range");

    property p_basic_rate;
        @(posedge ref_clk) disable iff (rst)
        !ext_class && tick |=> (s_reg.rate == ortt_pkg::RATE_2M || s_reg.rate == ortt_pkg::RATE_4M);
    endproperty
    a_basic_rate: assert property (p_basic_rate) else $error("basic class rate too high");

    property p_auto_rate;
        @(posedge ref_clk) disable iff (rst)
        (ext_class && s_reg.ctrl[ortt_pkg::CTRL_AUTO] && tick)
            |=> s_reg.rate == ortt_pkg::ortt_rate_t'($past(auto_rate));
    endproperty
    a_auto_rate: assert property (p_auto_rate) else $error("auto rate not taken");

    property p_key_only;
        @(posedge ref_clk) disable iff (rst)
        $changed(s_reg.test_active) |-> $past(key_rise);
    endproperty
    a_key_only: assert property (p_key_only) else $error("test mode changed without key");

    property p_mode_boundary;
        @(posedge ref_clk) disable iff (rst)
        !tick |=> $stable(s_reg.mode);
    endproperty
    a_mode_boundary: assert property (p_mode_boundary) else $error("mode changed mid cell");

    sequence s_master_zero_bit;
        s_reg.mode == ortt_pkg::MODE_NORMAL && is_master && tick && !tx_bit;
    endsequence

    property p_master_code;
        @(posedge ref_clk) disable iff (rst)
        s_master_zero_bit |-> s_toggled;
    endproperty
    a_master_code: assert property (p_master_code) else $error("zero bit not toggled");

    property p_master_hold;
        @(posedge ref_clk) disable iff (rst)
        (s_reg.mode == ortt_pkg::MODE_NORMAL && is_master && !(tick && !tx_bit))
            |=> $stable(opt_tx);
    endproperty
    a_master_hold: assert property (p_master_hold) else $error("master line moved");

    property p_idle_normal;
        @(posedge ref_clk) disable iff (rst)
        (!s_reg.test_active && tick) |=> s_reg.mode == ortt_pkg::MODE_NORMAL;
    endproperty
    a_idle_normal: assert property (p_idle_normal) else $error("test pattern without key");

    property p_basic_manual;
        @(posedge ref_clk) disable iff (rst)
        (!ext_class && tick && !s_reg.ctrl[ortt_pkg::CTRL_RATE_LSB + 1])
            |=> s_reg.rate ==
                ortt_pkg::ortt_rate_t'($past(s_reg.ctrl[ortt_pkg::CTRL_RATE_LSB +: 2]));
    endproperty
    a_basic_manual: assert property (p_basic_manual) else $error("basic rate not manual");

    property p_ext_manual;
        @(posedge ref_clk) disable iff (rst)
        (ext_class && !s_reg.ctrl[ortt_pkg::CTRL_AUTO] && tick)
            |=> s_reg.rate ==
                ortt_pkg::ortt_rate_t'($past(s_reg.ctrl[ortt_pkg::CTRL_RATE_LSB +: 2]));
    endproperty
    a_ext_manual: assert property (p_ext_manual) else $error("manual rate not taken");

endmodule // ortt_tx

`default_nettype wire

// File: verif/ortt_opt_link.sv
// Behavioural model of the optical transmitter that counts light level changes.
`default_nettype none

module ortt_opt_link (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Drive from the block under test
    input  wire logic        opt_tx,
    // Light level changes seen since reset
    output logic [15:0]      edges
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_reg;

    // The emitter has a single drive line, so test patterns and traffic share it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_reg <= 1'b0;
            edges    <= 16'h0000;
        end else begin
            last_reg <= opt_tx;
            if (opt_tx !== last_reg) begin
                edges <= edges + 16'h0001;
            end
        end
    end
endmodule // ortt_opt_link

`default_nettype wire

// File: verif/tb_optical_ring_test_pattern_tx.sv
// Self-checking testbench of the optical ring test pattern transmitter.
`default_nettype none

module tb_optical_ring_test_pattern_tx;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {int due; logic v;} ortt_note_t;
    typedef struct {logic [31:0] m; logic [31:0] d; logic e;} ortt_rd_t;

    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        light_in = 1'b0;
    logic        test_key = 1'b0;
    logic        tx_bit = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [1:0]  auto_rate = 2'h1;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        opt_tx;
    logic        bit_strobe;
    logic [15:0] edges;
    logic [31:0] seed = 32'h14;
    int          cyc = 0;
    int          bad_count = 0;
    int          checks_done = 0;
    ortt_note_t  oq[$];
    ortt_rd_t    rq[$];

    always #20 ref_clk = ~ref_clk;

    ortt_tx ortt_tx_i (.ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .light_in(light_in), .opt_tx(opt_tx),
        .test_key(test_key), .tx_bit(tx_bit), .bit_strobe(bit_strobe), .auto_rate(auto_rate));

    ortt_opt_link ortt_opt_link_i (.ref_clk(ref_clk), .rst(rst), .opt_tx(opt_tx), .edges(edges));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Calls start just after a rising edge; the trailing edge keeps two requests apart.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] d,
                      input logic e);
        rq.push_back('{m, d, e});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic note(input int dly, input logic v);
        oq.push_back('{cyc + dly, v});
    endtask

    task automatic press();
        test_key <= 1'b1;
        repeat (3) @(posedge ref_clk);
        test_key <= 1'b0;
        repeat (3) @(posedge ref_clk);
    endtask

    task automatic wait_edges(input int n);
        logic [15:0] e0;
        int          k;
        e0 = edges;
        k = 0;
        while (int'(16'(edges - e0)) < n && k < 3000) begin
            @(posedge ref_clk);
            k++;
        end
    endtask

    // Eighty bit cells span exactly 1000 cycles at 2 Mbit/s, halving per rate step.
    task automatic measure(input int r);
        int c0;
        wait_edges(2);
        c0 = cyc;
        wait_edges(80);
        chk("cycles per 80 cells", 32'(1000 >> r), 32'(cyc - c0));
    endtask

    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc > 30000) begin
            bad_count++;
            end_of_test();
        end
        while (oq.size() > 0 && oq[0].due <= cyc) begin
            chk("opt_tx", {31'h0, oq[0].v}, {31'h0, opt_tx});
            void'(oq.pop_front());
        end
        if (psel && penable && pready === 1'b1 && !pwrite && rq.size() > 0) begin
            chk("prdata", rq[0].d, prdata & rq[0].m);
            chk("pslverr", {31'h0, rq[0].e}, {31'h0, pslverr});
            void'(rq.pop_front());
        end
    end

    initial begin
        int          k;
        logic        ex;
        logic [31:0] t;
        logic [7:0]  cfg[6];
        int          er[6];
        // The last entry asks for auto baud on a basic station, which must keep the manual rate.
        cfg = '{8'h18, 8'h28, 8'h68, 8'h78, 8'hc8, 8'h88};
        er = '{1, 0, 2, 3, 1, 0};
        ex = 1'b0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        for (int i = 0; i < 30; i++) begin
            k = 0;
            @(posedge ref_clk);
            while (bit_strobe !== 1'b1 && k < 40) begin
                @(posedge ref_clk);
                k++;
            end
            chk("bit_strobe", 32'h1, {31'h0, bit_strobe});
            ex = ex ^ ~tx_bit;
            note(3, ex);
            t = rnd();
            tx_bit <= t[0];
        end
        rd(ortt_pkg::CTRL_OFFSET, 32'hffffffff, 32'h00000008, 1'b0);
        rd(12'h008, 32'hffffffff, 32'h0, 1'b1);
        // A write with the low byte lane disabled must leave the control byte alone.
        pstrb <= 4'he;
        apb(1'b1, ortt_pkg::CTRL_OFFSET, 32'hff);
        pstrb <= 4'hf;
        rd(ortt_pkg::CTRL_OFFSET, 32'hffffffff, 32'h00000008, 1'b0);
        tx_bit <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, ortt_pkg::CTRL_OFFSET, {24'h0, cfg[i]});
            measure(er[i]);
        end
        apb(1'b1, ortt_pkg::CTRL_OFFSET, 32'h09);
        repeat (30) @(posedge ref_clk);
        rd(ortt_pkg::STATUS_OFFSET, 32'h1f, 32'h0, 1'b0);
        press();
        repeat (30) @(posedge ref_clk);
        rd(ortt_pkg::STATUS_OFFSET, 32'h3f, 32'h05, 1'b0);
        for (int i = 1; i <= 100; i++) note(i, 1'b1);
        repeat (102) @(posedge ref_clk);
        apb(1'b1, ortt_pkg::CTRL_OFFSET, 32'h02);
        measure(0);
        apb(1'b1, ortt_pkg::CTRL_OFFSET, 32'h7a);
        measure(3);
        rd(ortt_pkg::STATUS_OFFSET, 32'h1f, 32'h1e, 1'b0);
        press();
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, ortt_pkg::CTRL_OFFSET, 32'(inv << 2));
            repeat (20) @(posedge ref_clk);
            for (int i = 0; i < 100; i++) begin
                t = rnd();
                light_in <= t[0];
                note(4, t[0] ^ inv[0]);
                @(posedge ref_clk);
            end
            repeat (6) @(posedge ref_clk);
        end
        chk("pending notes", 32'h0, 32'(oq.size() + rq.size()));
        end_of_test();
    end
endmodule // tb_optical_ring_test_pattern_tx

`default_nettype wire
